// File: rtl/incdec_pkg.sv
// Constants, operation codes and carrier types of the inc/dec/power-down core
package incdec_pkg;
  localparam int          DATA_W       = 8;
  localparam int          MEM_DEPTH    = 16;
  localparam int          MEM_AW       = 4;
  localparam int          BUS_AW       = 8;
  localparam logic [7:0]  ONE          = 8'h01;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  // Bus map: data memory at 0x00..0x0f, then accumulator and status
  localparam logic [7:0]  MEM_BASE     = 8'h00;
  localparam logic [7:0]  MEM_LAST     = 8'h0f;
  localparam logic [7:0]  ACCUM_ADDR   = 8'h10;
  localparam logic [7:0]  STATUS_ADDR  = 8'h11;
  // Status register bit positions
  localparam int          ST_ZERO      = 0;
  localparam int          ST_CARRY     = 1;
  localparam int          ST_PWR_DOWN  = 2;
  localparam int          ST_TOF       = 3;
  localparam logic [7:0]  ACCUM_RESET  = 8'h00;
  localparam logic        READY_RESET  = 1'b1;
  localparam logic [7:0]  MEM_RESET    = 8'h00;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_DEC_TO_ACCUM,
    OP_INC_MEM,
    OP_INC_TO_ACCUM,
    OP_POWER_DOWN
  } op_t;

  typedef struct packed {
    logic              valid;
    op_t               op;
    logic [MEM_AW-1:0] addr;
  } instr_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [BUS_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;
endpackage : incdec_pkg

// File: rtl/incdec_alu.sv
// Increment/decrement datapath with zero detection
`timescale 1ns/100ps
module incdec_alu (
  input  wire incdec_pkg::op_t  op,
  input  wire logic [7:0]       operand,
  output logic      [7:0]       result,
  output logic                  zero
);
  always_comb begin
    // Modulo-256 wrap comes free from the 8-bit width
    if (op == incdec_pkg::OP_DEC_TO_ACCUM) begin
      result = operand - incdec_pkg::ONE;
    end else begin
      result = operand + incdec_pkg::ONE;
    end
    zero = (result == incdec_pkg::BYTE_ZERO);
  end
endmodule : incdec_alu

// File: rtl/incdec_core.sv
// Core executing decrement/increment and power-down instructions
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
module incdec_core (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire incdec_pkg::instr_t      instr,
  input  wire incdec_pkg::bus_req_t    bus,
  input  wire logic                    watchdog_timeout_event,
  output logic                         instr_ready,
  output logic [7:0]                   rdata,
  output logic [7:0]                   accumulator,
  output logic                         zero_flag,
  output logic                         power_down_flag,
  output logic                         watchdog_timeout_flag,
  output logic                         clock_gated,
  output logic                         watchdog_clear
);
  typedef struct packed {
    logic [incdec_pkg::MEM_DEPTH-1:0][7:0] mem;
    logic [7:0]                            accum;
    logic                                  zero;
    logic                                  carry;
    logic                                  pwr_down;
    logic                                  tof;
    logic                                  halted;
    logic                                  ready;
    logic                                  wdog_clr;
    logic [7:0]                            rdata;
  } state_t;

  state_t     s_reg;
  state_t     s_next;
  logic       take;
  logic [7:0] operand;
  logic [7:0] alu_result;
  logic       alu_zero;
  logic       bus_mem_hit;

  assign take        = instr.valid && !s_reg.halted;
  assign operand     = s_reg.mem[instr.addr];
  assign bus_mem_hit = (bus.addr <= incdec_pkg::MEM_LAST);

  incdec_alu u_incdec_alu (
    .op      (instr.op),
    .operand (operand),
    .result  (alu_result),
    .zero    (alu_zero)
  );

  always_comb begin
    s_next         = s_reg;
    s_next.wdog_clr = 1'b0;
    s_next.rdata   = incdec_pkg::BYTE_ZERO;
    // Register port; stays live in power down so software can inspect state
    if (bus.rd) begin
      if (bus_mem_hit) begin
        s_next.rdata = s_reg.mem[bus.addr[incdec_pkg::MEM_AW-1:0]];
      end else if (bus.addr == incdec_pkg::ACCUM_ADDR) begin
        s_next.rdata = s_reg.accum;
      end else if (bus.addr == incdec_pkg::STATUS_ADDR) begin
        s_next.rdata[incdec_pkg::ST_ZERO]     = s_reg.zero;
        s_next.rdata[incdec_pkg::ST_CARRY]    = s_reg.carry;
        s_next.rdata[incdec_pkg::ST_PWR_DOWN] = s_reg.pwr_down;
        s_next.rdata[incdec_pkg::ST_TOF]   = s_reg.tof;
      end
    end
    if (bus.wr) begin
      if (bus_mem_hit) begin
        s_next.mem[bus.addr[incdec_pkg::MEM_AW-1:0]] = bus.wdata;
      end else if (bus.addr == incdec_pkg::ACCUM_ADDR) begin
        s_next.accum = bus.wdata;
      end else if (bus.addr == incdec_pkg::STATUS_ADDR) begin
        s_next.zero     = bus.wdata[incdec_pkg::ST_ZERO];
        s_next.carry    = bus.wdata[incdec_pkg::ST_CARRY];
        s_next.pwr_down = bus.wdata[incdec_pkg::ST_PWR_DOWN];
        s_next.tof   = bus.wdata[incdec_pkg::ST_TOF];
      end
    end
    // Instruction writes after the bus so it wins a same-cycle collision
    if (take) begin
      case (instr.op)
        incdec_pkg::OP_DEC_TO_ACCUM,
        incdec_pkg::OP_INC_TO_ACCUM: begin
          s_next.accum = alu_result;
          s_next.zero = alu_zero;
        end
        incdec_pkg::OP_INC_MEM: begin
          s_next.mem[instr.addr] = alu_result;
          s_next.zero            = alu_zero;
        end
        incdec_pkg::OP_POWER_DOWN: begin
          // Memory, accumulator and other flags are left as they are
          s_next.halted   = 1'b1;
          s_next.ready    = 1'b0;
          s_next.wdog_clr = 1'b1;
          s_next.pwr_down = 1'b1;
          s_next.tof     = 1'b0;
        end
        default: begin
          s_next.halted = s_reg.halted;
        end
      endcase
    end
    // A time-out in the same cycle as a clear must not be lost
    if (watchdog_timeout_event) begin
      s_next.tof = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_reg     <= '0;
      s_reg.accum <= incdec_pkg::ACCUM_RESET;
      s_reg.ready <= incdec_pkg::READY_RESET;
      for (int i = 0; i < incdec_pkg::MEM_DEPTH; i++) begin
        s_reg.mem[i] <= incdec_pkg::MEM_RESET;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // Exit from power down is only by reset: wake-up lies outside this block
  // Ready has a flop of its own so the pin is not an inverter after halted
  assign instr_ready           = s_reg.ready;
  assign clock_gated           = s_reg.halted;
  assign rdata                 = s_reg.rdata;
  assign accumulator           = s_reg.accum;
  assign zero_flag             = s_reg.zero;
  assign power_down_flag       = s_reg.pwr_down;
  assign watchdog_timeout_flag = s_reg.tof;
  assign watchdog_clear        = s_reg.wdog_clr;

  logic is_dec;
  logic is_inc_accum;
  logic is_incm;
  logic is_pd;
  assign is_dec       = take && instr.op == incdec_pkg::OP_DEC_TO_ACCUM;
  assign is_inc_accum = take && instr.op == incdec_pkg::OP_INC_TO_ACCUM;
  assign is_incm = take && instr.op == incdec_pkg::OP_INC_MEM;
  assign is_pd   = take && instr.op == incdec_pkg::OP_POWER_DOWN;

  property p_dec_accum;
    @(posedge clk) disable iff (!reset_n)
      is_dec |=> accumulator == $past(operand) - 8'h01
                 && zero_flag == (accumulator == 8'h00);
  endproperty
  a_dec_accum: assert property (p_dec_accum)
    else $error("decrement result wrong in accumulator");

  property p_mem_kept;
    @(posedge clk) disable iff (!reset_n)
      (is_dec || is_inc_accum) && !bus.wr |=> s_reg.mem == $past(s_reg.mem);
  endproperty
  a_mem_kept: assert property (p_mem_kept)
    else $error("memory changed by accumulator-result instruction");

  sequence s_stopped;
    clock_gated && !instr_ready;
  endsequence
  property p_stop;
    @(posedge clk) disable iff (!reset_n)
      is_pd |=> s_stopped ##1 s_stopped ##1 s_stopped;
  endproperty
  a_stop: assert property (p_stop)
    else $error("power down did not stop execution");

  property p_retain;
    @(posedge clk) disable iff (!reset_n)
      s_reg.halted && !bus.wr |=> $stable(s_reg.mem)
        && $stable(accumulator) && $stable(zero_flag) && $stable(s_reg.carry);
  endproperty
  a_retain: assert property (p_retain)
    else $error("state lost while powered down");

  sequence s_clear_pulse;
    watchdog_clear ##1 !watchdog_clear;
  endsequence
  property p_wdog_clear;
    @(posedge clk) disable iff (!reset_n)
      is_pd |=> s_clear_pulse;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear)
    else $error("watchdog clear pulse missing");

  property p_flags;
    @(posedge clk) disable iff (!reset_n)
      is_pd && !watchdog_timeout_event && !bus.wr |=>
        power_down_flag && !watchdog_timeout_flag
        && zero_flag == $past(zero_flag);
  endproperty
  a_flags: assert property (p_flags)
    else $error("power down flags wrong");

  property p_inc_mem;
    @(posedge clk) disable iff (!reset_n)
      is_incm && !bus.wr |=>
        s_reg.mem[$past(instr.addr)] == $past(operand) + 8'h01
                  && accumulator == $past(accumulator);
  endproperty
  a_inc_mem: assert property (p_inc_mem)
    else $error("increment of memory wrong");

  property p_inc_accum;
    @(posedge clk) disable iff (!reset_n)
      is_inc_accum |=> accumulator == $past(operand) + 8'h01;
  endproperty
  a_inc_accum: assert property (p_inc_accum)
    else $error("increment result wrong in accumulator");

  property p_zero_carry;
    @(posedge clk) disable iff (!reset_n)
      (is_dec || is_inc_accum || is_incm) && !bus.wr |=>
        zero_flag == ($past(alu_result) == 8'h00) && $stable(s_reg.carry);
  endproperty
  a_zero_carry: assert property (p_zero_carry)
    else $error("zero or carry flag wrong");
endmodule : incdec_core

// File: tb/incdec_core_tb.sv
// Self-checking bench of the inc/dec/power-down core
`timescale 1ns/100ps
module incdec_core_tb;
  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  incdec_pkg::instr_t   instr = '0;
  incdec_pkg::bus_req_t bus = '0;
  logic                 watchdog_timeout_event = 1'b0;
  logic                 instr_ready;
  logic [7:0]           rdata;
  logic [7:0]           accumulator;
  logic                 zero_flag;
  logic                 power_down_flag;
  logic                 watchdog_timeout_flag;
  logic                 clock_gated;
  logic                 watchdog_clear;
  int                   n_errors = 0;
  int                   tests_run = 0;
  logic [7:0]           v;

  localparam incdec_pkg::op_t DEC_ACCUM = incdec_pkg::OP_DEC_TO_ACCUM;
  localparam incdec_pkg::op_t INC_ACCUM = incdec_pkg::OP_INC_TO_ACCUM;
  localparam incdec_pkg::op_t INC_MEM   = incdec_pkg::OP_INC_MEM;

  always #10 clk = ~clk;

  incdec_core u_incdec_core (
    .clk(clk), .reset_n(reset_n), .instr(instr), .bus(bus),
    .watchdog_timeout_event(watchdog_timeout_event),
    .instr_ready(instr_ready), .rdata(rdata), .accumulator(accumulator),
    .zero_flag(zero_flag), .power_down_flag(power_down_flag),
    .watchdog_timeout_flag(watchdog_timeout_flag),
    .clock_gated(clock_gated), .watchdog_clear(watchdog_clear)
  );

  task automatic end_sim;
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic chk1(input string name, input logic seen, input logic exp);
    chk(name, {7'h00, seen}, {7'h00, exp});
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk) bus <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) bus <= '0;
    #1 d = rdata;
  endtask : rd

  task automatic ex(input incdec_pkg::op_t op, input logic [3:0] a);
    @(posedge clk) instr <= '{1'b1, op, a};
    @(posedge clk) instr <= '0;
    #1;
  endtask : ex

  task automatic op_case(input incdec_pkg::op_t op, input logic [3:0] a,
                         input logic [7:0] m, input logic [7:0] accum_e,
                         input logic z_e, input logic [7:0] m_e);
    wr({4'h0, a}, m);
    ex(op, a);
    chk("accumulator", accumulator, accum_e);
    chk1("zero_flag", zero_flag, z_e);
    rd({4'h0, a}, v);
    chk("memory", v, m_e);
  endtask : op_case

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk("accumulator", accumulator, 8'h00);
    chk1("instr_ready", instr_ready, 1'b1);
    // Carry set first so that any disturbance by the ops shows
    wr(incdec_pkg::STATUS_ADDR, 8'h02);
    op_case(INC_ACCUM, 4'h3, 8'hff, 8'h00, 1'b1, 8'hff);
    op_case(INC_ACCUM, 4'h4, 8'h7f, 8'h80, 1'b0, 8'h7f);
    op_case(DEC_ACCUM, 4'h5, 8'h01, 8'h00, 1'b1, 8'h01);
    op_case(DEC_ACCUM, 4'h6, 8'h00, 8'hff, 1'b0, 8'h00);
    op_case(INC_MEM, 4'h7, 8'hff, 8'hff, 1'b1, 8'h00);
    op_case(INC_MEM, 4'h8, 8'h41, 8'hff, 1'b0, 8'h42);
    rd(incdec_pkg::STATUS_ADDR, v);
    chk("status", v, 8'h02);
    // Back to back: second op must see the first one's sum
    @(posedge clk) instr <= '{1'b1, INC_MEM, 4'h9};
    @(posedge clk) instr <= '{1'b1, INC_ACCUM, 4'h9};
    @(posedge clk) instr <= '0;
    #1 chk("accumulator", accumulator, 8'h02);
    rd(8'h09, v);
    chk("memory", v, 8'h01);
    @(posedge clk) watchdog_timeout_event <= 1'b1;
    @(posedge clk) watchdog_timeout_event <= 1'b0;
    #1 chk1("watchdog_timeout_flag", watchdog_timeout_flag, 1'b1);
    ex(incdec_pkg::OP_POWER_DOWN, 4'h0);
    chk1("instr_ready", instr_ready, 1'b0);
    chk1("clock_gated", clock_gated, 1'b1);
    chk1("power_down_flag", power_down_flag, 1'b1);
    chk1("watchdog_timeout_flag", watchdog_timeout_flag, 1'b0);
    chk1("watchdog_clear", watchdog_clear, 1'b1);
    chk("accumulator", accumulator, 8'h02);
    @(posedge clk) #1 chk1("watchdog_clear", watchdog_clear, 1'b0);
    rd(incdec_pkg::STATUS_ADDR, v);
    chk("status", v, 8'h06);
    // Instructions offered while powered down must be ignored
    ex(INC_ACCUM, 4'h3);
    ex(INC_MEM, 4'h3);
    chk("accumulator", accumulator, 8'h02);
    rd(8'h03, v);
    chk("memory", v, 8'hff);
    rd(8'h04, v);
    chk("memory", v, 8'h7f);
    chk1("clock_gated", clock_gated, 1'b1);
    // Reset is the only way back out of power down
    @(posedge clk) reset_n <= 1'b0;
    @(posedge clk) reset_n <= 1'b1;
    #1 chk1("instr_ready", instr_ready, 1'b1);
    chk1("clock_gated", clock_gated, 1'b0);
    chk1("power_down_flag", power_down_flag, 1'b0);
    ex(INC_ACCUM, 4'h3);
    chk("accumulator", accumulator, 8'h01);
    end_sim;
  end

  // The sequence needs about 70 cycles
  initial begin
    #(20 * 1000);
    n_errors++;
    end_sim;
  end
endmodule : incdec_core_tb
